// >>> rtl/radio_evt_pkg.sv
// Package for the radio task, event and shortcut register bank
package radio_evt_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ****************************************************************
  // Task offsets (the strength begin offset is our own choice)
  // ****************************************************************
  localparam logic [11:0] OFS_TASK_STRENGTH_BEGIN       = 12'h014;
  localparam logic [11:0] OFS_TASK_STRENGTH_HALT        = 12'h018;
  localparam logic [11:0] OFS_TASK_BITCOUNT_BEGIN       = 12'h01C;
  localparam logic [11:0] OFS_TASK_BITCOUNT_HALT        = 12'h020;
  localparam logic [11:0] OFS_TASK_ENERGY_SCAN_BEGIN    = 12'h024;
  localparam logic [11:0] OFS_TASK_ENERGY_SCAN_HALT     = 12'h028;
  localparam logic [11:0] OFS_TASK_CHANNEL_CHECK_BEGIN  = 12'h02C;
  localparam logic [11:0] OFS_TASK_CHANNEL_CHECK_HALT   = 12'h030;

  // ****************************************************************
  // Event offsets, indexed by event number
  // ****************************************************************
  localparam int NUM_EVT = 25;
  localparam logic [11:0] EVT_OFS [NUM_EVT] = '{
    12'h100, 12'h104, 12'h108, 12'h10C, 12'h110, 12'h114, 12'h118,
    12'h11C, 12'h128, 12'h130, 12'h134, 12'h138, 12'h13C, 12'h140,
    12'h144, 12'h148, 12'h14C, 12'h150, 12'h154, 12'h158, 12'h15C,
    12'h168, 12'h16C, 12'h170, 12'h000};

  // Event numbers
  localparam int EV_READY       = 0;
  localparam int EV_ADDRESS     = 1;
  localparam int EV_PAYLOAD     = 2;
  localparam int EV_PACKET      = 3;
  localparam int EV_RADIO_OFF   = 4;
  localparam int EV_PEER_MATCH  = 5;
  localparam int EV_PEER_NOM    = 6;
  localparam int EV_STRENGTH    = 7;
  localparam int EV_BITCOUNT    = 8;
  localparam int EV_CHECK_PASS  = 9;
  localparam int EV_CHECK_FAIL  = 10;
  localparam int EV_FRAME_LEN   = 11;
  localparam int EV_ENERGY_DONE = 12;
  localparam int EV_ENERGY_HALT = 13;
  localparam int EV_CLEAR       = 14;
  localparam int EV_OCCUPIED    = 15;
  localparam int EV_CHECK_HALT  = 16;
  localparam int EV_UPSHIFT     = 17;
  localparam int EV_TX_RAMPED   = 18;
  localparam int EV_RX_RAMPED   = 19;
  localparam int EV_MAC_HIT     = 20;
  localparam int EV_PREAMBLE    = 21;
  localparam int EV_LAST_BIT    = 22;
  localparam int EV_TONE_EXT    = 23;
  localparam int NUM_HW_EVT     = 24;

  // ****************************************************************
  // Shortcut register and its fields
  // ****************************************************************
  localparam logic [11:0] OFS_EVENT_TASK_LINKS   = 12'h200;
  localparam logic [31:0] RST_EVENT_TASK_LINKS   = 32'h0000_0000;
  localparam int          LINK_W                 = 6;
  localparam int          LINK_READY_START       = 0;
  localparam int          LINK_END_DISABLE       = 1;
  localparam int          LINK_OFF_TRANSMIT_ENABLE_TASK          = 2;
  localparam int          LINK_OFF_RECEIVE_ENABLE_TASK          = 3;
  localparam int          LINK_ADDR_STRENGTH     = 4;
  localparam int          LINK_END_START         = 5;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic strength_begin;
    logic strength_halt;
    logic bitcount_begin;
    logic bitcount_halt;
    logic energy_scan_begin;
    logic energy_scan_halt;
    logic channel_check_begin;
    logic channel_check_halt;
    logic radio_start;
    logic radio_disable;
    logic transmit_enable_task;
    logic receive_enable_task;
  } task_pulse_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;

endpackage

// >>> rtl/radio_task_event_shortcut_regs.sv
// Task, event and shortcut register bank of the radio
// Behaviour
// - Writing 1 begins one strength sample; writing 1 at 0x018 halts it.
// - Writing 1 at 0x01C starts the bit counter; 0x020 stops it.
// - Writing 1 at 0x024 begins energy scan; 0x028 halts it.
// - Writing 1 at 0x02C begins channel check; 0x030 halts it.
// - Ramp-up complete sets bit 0 of the ready event at 0x100.
// - Address done sets 0x104; payload done sets 0x108.
// - Complete packet sets the end event at 0x10C.
// - Radio reaching off sets the event at 0x110.
// - Received packet sets peer match 0x114 or else peer no-match 0x118.
// - Strength sampling done sets 0x11C with a fresh value readable.
// - Bit counter reaching the compare value sets 0x128.
// - Good check sets 0x130; bad check sets 0x134.
// - Length field seen sets 0x138; header pattern hit sets 0x15C.
// - Energy sample ready sets 0x13C; energy scan stop sets 0x140.
// - Channel clear sets 0x144, occupied 0x148, check stopped 0x14C.
// - Coded rate upshift in long range reception sets 0x150.
// - Transmit path ramped sets 0x154; receive path ramped sets 0x158.
// - Preamble hint sets 0x168 and may fire falsely.
// - Last bit on air, sent or received, sets 0x16C.
// - Tone extension info byte taken in sets 0x170.
// - Link bits: A ready to start, B end to disable, F end to start.
// - C and D enable on radio off; E begins strength on address.
`timescale 1ns/1ps
`default_nettype none

module radio_task_event_shortcut_regs
  import radio_evt_pkg::*;
#(
  parameter int STRENGTH_W = 7,
  parameter int ENERGY_W   = 8,
  parameter int BITCOUNT_W = 32
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  // Register port
  input  wire radio_evt_pkg::bus_req_s           bus_req,
  output logic [radio_evt_pkg::DATA_W-1:0]       rdata,
  // Event strobes from the radio core
  input  wire logic [radio_evt_pkg::NUM_HW_EVT-1:0] hw_event,
  input  wire logic                              bit_tick,
  input  wire logic [STRENGTH_W-1:0]             strength_sample,
  input  wire logic [ENERGY_W-1:0]               energy_sample,
  // Task pulses to the radio core
  output radio_evt_pkg::task_pulse_s             task_pulse,
  // Status
  output logic                                   bitcount_running,
  output logic [STRENGTH_W-1:0]                  strength_value,
  output logic [ENERGY_W-1:0]                    energy_sample_value
);
  import radio_evt_pkg::*;

  // ****************************************************************
  // Own register offsets
  // ****************************************************************
  localparam logic [11:0] OFS_BITCOUNT_COMPARE = 12'h560;
  localparam logic [11:0] OFS_STRENGTH_VALUE   = 12'h548;
  localparam logic [11:0] OFS_ENERGY_VALUE     = 12'h668;
  localparam logic [11:0] OFS_BITCOUNT_NOW     = 12'h564;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire logic wr1 = bus_req.wr & bus_req.wdata[0];
  wire logic hit_sb  = bus_req.addr == OFS_TASK_STRENGTH_BEGIN;
  wire logic hit_sh  = bus_req.addr == OFS_TASK_STRENGTH_HALT;
  wire logic hit_bb  = bus_req.addr == OFS_TASK_BITCOUNT_BEGIN;
  wire logic hit_bh  = bus_req.addr == OFS_TASK_BITCOUNT_HALT;
  wire logic hit_eb  = bus_req.addr == OFS_TASK_ENERGY_SCAN_BEGIN;
  wire logic hit_eh  = bus_req.addr == OFS_TASK_ENERGY_SCAN_HALT;
  wire logic hit_cb  = bus_req.addr == OFS_TASK_CHANNEL_CHECK_BEGIN;
  wire logic hit_ch  = bus_req.addr == OFS_TASK_CHANNEL_CHECK_HALT;
  wire logic hit_lnk = bus_req.addr == OFS_EVENT_TASK_LINKS;
  wire logic hit_bcc = bus_req.addr == OFS_BITCOUNT_COMPARE;

  logic [NUM_HW_EVT-1:0] evt_r;
  logic [NUM_HW_EVT-1:0] evt_set;
  logic [NUM_HW_EVT-1:0] evt_hit;
  logic [LINK_W-1:0]     links_r;
  logic [BITCOUNT_W-1:0] bcc_r;
  logic [BITCOUNT_W-1:0] bitcnt_r;
  logic                  bc_run_r;
  logic                  strength_pend_r;

  // ****************************************************************
  // Event flags: a hardware set wins over a software clear
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_HW_EVT; gi++) begin : g_evt
      assign evt_hit[gi] = bus_req.addr == EVT_OFS[gi];
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          evt_r[gi] <= 1'b0;
        end else if (evt_set[gi]) begin
          evt_r[gi] <= 1'b1;
        end else if (bus_req.wr && evt_hit[gi] && !bus_req.wdata[0]) begin
          evt_r[gi] <= 1'b0;
        end else if (bus_req.wr && evt_hit[gi]) begin
          evt_r[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // Bit counter hit and strength done are produced locally; the radio core drives the rest
  wire logic bc_hit = bc_run_r && bit_tick && (bitcnt_r + 1'b1 == bcc_r);
  wire logic strength_done = strength_pend_r;

  always_comb begin
    evt_set = hw_event;
    evt_set[EV_BITCOUNT] = bc_hit;
    evt_set[EV_STRENGTH] = strength_done;
  end

  // ****************************************************************
  // Tasks from software or shortcuts
  // ****************************************************************
  wire logic lk_rs = links_r[LINK_READY_START]   & evt_set[EV_READY];
  wire logic lk_ed = links_r[LINK_END_DISABLE]   & evt_set[EV_PACKET];
  wire logic lk_tx = links_r[LINK_OFF_TRANSMIT_ENABLE_TASK]      & evt_set[EV_RADIO_OFF];
  wire logic lk_rx = links_r[LINK_OFF_RECEIVE_ENABLE_TASK]      & evt_set[EV_RADIO_OFF];
  wire logic lk_as = links_r[LINK_ADDR_STRENGTH] & evt_set[EV_ADDRESS];
  wire logic lk_es = links_r[LINK_END_START]     & evt_set[EV_PACKET];

  // Writes of 0 leave tasks untouched
  assign task_pulse.strength_begin       = (wr1 & hit_sb) | lk_as;
  assign task_pulse.strength_halt        = wr1 & hit_sh;
  assign task_pulse.bitcount_begin       = wr1 & hit_bb;
  assign task_pulse.bitcount_halt        = wr1 & hit_bh;
  assign task_pulse.energy_scan_begin    = wr1 & hit_eb;
  assign task_pulse.energy_scan_halt     = wr1 & hit_eh;
  assign task_pulse.channel_check_begin  = wr1 & hit_cb;
  assign task_pulse.channel_check_halt   = wr1 & hit_ch;
  assign task_pulse.radio_start          = lk_rs | lk_es;
  assign task_pulse.radio_disable        = lk_ed;
  assign task_pulse.transmit_enable_task = lk_tx;
  assign task_pulse.receive_enable_task  = lk_rx;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      links_r <= RST_EVENT_TASK_LINKS[LINK_W-1:0];
      bcc_r   <= '0;
    end else begin
      if (bus_req.wr && hit_lnk) links_r <= bus_req.wdata[LINK_W-1:0];
      if (bus_req.wr && hit_bcc) bcc_r <= bus_req.wdata[BITCOUNT_W-1:0];
    end
  end

  // ****************************************************************
  // Bit counter: halt wins over begin in the same cycle
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bc_run_r <= 1'b0;
      bitcnt_r <= '0;
    end else if (task_pulse.bitcount_halt) begin
      bc_run_r <= 1'b0;
    end else if (task_pulse.bitcount_begin) begin
      bc_run_r <= 1'b1;
      bitcnt_r <= '0;
    end else if (bc_run_r && bit_tick) begin
      bitcnt_r <= bitcnt_r + 1'b1;
    end
  end

  // ****************************************************************
  // Strength sample: one capture per begin, halt cancels
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strength_pend_r <= 1'b0;
    end else if (task_pulse.strength_halt) begin
      strength_pend_r <= 1'b0;
    end else if (task_pulse.strength_begin) begin
      strength_pend_r <= 1'b1;
    end else if (strength_pend_r) begin
      strength_pend_r <= 1'b0;
    end
  end

  // Sample taken with the begin so it is readable when the done flag shows
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strength_value <= '0;
    end else if (task_pulse.strength_begin && !task_pulse.strength_halt) begin
      strength_value <= strength_sample;
    end
  end

  // Energy value latched on the sample-ready strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      energy_sample_value <= '0;
    end else if (hw_event[EV_ENERGY_DONE]) begin
      energy_sample_value <= energy_sample;
    end
  end

  assign bitcount_running = bc_run_r;

  // ****************************************************************
  // Read path: one cycle later; tasks and unmapped read zero
  // ****************************************************************
  logic [DATA_W-1:0] rd_nxt;
  always_comb begin
    rd_nxt = '0;
    for (int i = 0; i < NUM_HW_EVT; i++) begin
      if (evt_hit[i]) rd_nxt = {31'h0000_0000, evt_r[i]};
    end
    if (hit_lnk) rd_nxt = {{(DATA_W-LINK_W){1'b0}}, links_r};
    if (hit_bcc) rd_nxt = bcc_r;
    if (bus_req.addr == OFS_BITCOUNT_NOW) rd_nxt = bitcnt_r;
    if (bus_req.addr == OFS_STRENGTH_VALUE)
      rd_nxt = {{(DATA_W-STRENGTH_W){1'b0}}, strength_value};
    if (bus_req.addr == OFS_ENERGY_VALUE)
      rd_nxt = {{(DATA_W-ENERGY_W){1'b0}}, energy_sample_value};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else begin
      rdata <= bus_req.rd ? rd_nxt : '0;
    end
  end

endmodule

`default_nettype wire

// >>> verification/radio_regs_chk.sv
// Checker for the radio task, event and shortcut register bank
`timescale 1ns/1ps
`default_nettype none

module radio_regs_chk
  import radio_evt_pkg::*;
#(
  parameter int STRENGTH_W = 7,
  parameter int ENERGY_W   = 8,
  parameter int BITCOUNT_W = 32
) (
  // Clock and reset
  input wire logic                                   clk,
  input wire logic                                   reset_n,
  // Observed ports
  input wire radio_evt_pkg::bus_req_s                bus_req,
  input wire logic [radio_evt_pkg::DATA_W-1:0]       rdata,
  input wire logic [radio_evt_pkg::NUM_HW_EVT-1:0]   hw_event,
  input wire radio_evt_pkg::task_pulse_s             task_pulse,
  input wire logic                                   bitcount_running
);
  logic [LINK_W-1:0] links_r;
  wire logic         wr_one = bus_req.wr && bus_req.wdata[0];

  // Shadow of the link register, so link checks do not depend on a read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      links_r <= '0;
    end else if (bus_req.wr && bus_req.addr == OFS_EVENT_TASK_LINKS) begin
      links_r <= bus_req.wdata[LINK_W-1:0];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_bc_begin;
    wr_one && bus_req.addr == OFS_TASK_BITCOUNT_BEGIN |-> task_pulse.bitcount_begin ##1 bitcount_running;
  endproperty
  a_bc_begin: assert property (p_bc_begin) else $error("bit counter did not start");
  property p_bc_halt;
    wr_one && bus_req.addr == OFS_TASK_BITCOUNT_HALT |=> !bitcount_running;
  endproperty
  a_bc_halt: assert property (p_bc_halt) else $error("bit counter did not stop");
  property p_ed;
    wr_one && bus_req.addr == OFS_TASK_ENERGY_SCAN_BEGIN |-> task_pulse.energy_scan_begin;
  endproperty
  a_ed: assert property (p_ed) else $error("energy scan begin pulse missing");
  property p_rssi_halt;
    wr_one && bus_req.addr == OFS_TASK_STRENGTH_HALT |-> task_pulse.strength_halt;
  endproperty
  a_rssi_halt: assert property (p_rssi_halt) else $error("strength halt pulse missing");
  property p_zero_wr;
    !wr_one && hw_event == '0 |-> task_pulse == '0;
  endproperty
  a_zero_wr: assert property (p_zero_wr) else $error("task pulse without cause");
  property p_task_rd;
    bus_req.rd && bus_req.addr >= 12'h014 && bus_req.addr <= 12'h030 |=> rdata == '0;
  endproperty
  a_task_rd: assert property (p_task_rd) else $error("task read not zero");
  property p_link_start;
    task_pulse.radio_start == ((hw_event[EV_READY] && links_r[LINK_READY_START])
                               || (hw_event[EV_PACKET] && links_r[LINK_END_START]));
  endproperty
  a_link_start: assert property (p_link_start) else $error("start link wrong");
  property p_link_dis;
    hw_event[EV_PACKET] && links_r[LINK_END_DISABLE] |-> task_pulse.radio_disable;
  endproperty
  a_link_dis: assert property (p_link_dis) else $error("disable link missing");
  property p_link_en;
    hw_event[EV_RADIO_OFF] |-> task_pulse.transmit_enable_task == links_r[LINK_OFF_TRANSMIT_ENABLE_TASK]
                               && task_pulse.receive_enable_task == links_r[LINK_OFF_RECEIVE_ENABLE_TASK];
  endproperty
  a_link_en: assert property (p_link_en) else $error("enable links wrong");
  property p_link_rssi;
    hw_event[EV_ADDRESS] && links_r[LINK_ADDR_STRENGTH] |-> task_pulse.strength_begin;
  endproperty
  a_link_rssi: assert property (p_link_rssi) else $error("strength link missing");
endmodule

bind radio_task_event_shortcut_regs radio_regs_chk #(
  .STRENGTH_W(STRENGTH_W),
  .ENERGY_W  (ENERGY_W),
  .BITCOUNT_W(BITCOUNT_W)
) i_radio_regs_chk (
  .clk             (clk),
  .reset_n         (reset_n),
  .bus_req         (bus_req),
  .rdata           (rdata),
  .hw_event        (hw_event),
  .task_pulse      (task_pulse),
  .bitcount_running(bitcount_running)
);

`default_nettype wire

// >>> verification/tb.sv
// Testbench for the radio task, event and shortcut register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
  import radio_evt_pkg::*;
  logic                  clk;
  logic                  reset_n;
  bus_req_s              bus_req;
  logic [DATA_W-1:0]     rdata;
  logic [NUM_HW_EVT-1:0] hw_event;
  logic                  bit_tick;
  logic [6:0]            strength_sample;
  logic [7:0]            energy_sample;
  task_pulse_s           task_pulse;
  logic                  bitcount_running;
  logic [6:0]            strength_value;
  logic [7:0]            energy_sample_value;
  int                    n_fail;
  int                    n_tests;
  logic [31:0]           got;
  logic [11:0]           tp;
  int                    lev[4] = '{EV_READY, EV_PACKET, EV_RADIO_OFF, EV_ADDRESS};
  logic [11:0]           lexp[4] = '{12'h008, 12'h00C, 12'h003, 12'h800};

  always #2 clk = ~clk;

  radio_task_event_shortcut_regs i_radio_task_event_shortcut_regs (
    .clk                (clk),
    .reset_n            (reset_n),
    .bus_req            (bus_req),
    .rdata              (rdata),
    .hw_event           (hw_event),
    .bit_tick           (bit_tick),
    .strength_sample    (strength_sample),
    .energy_sample      (energy_sample),
    .task_pulse         (task_pulse),
    .bitcount_running   (bitcount_running),
    .strength_value     (strength_value),
    .energy_sample_value(energy_sample_value)
  );

  // ****************************************************************
  // Bus and stimulus tasks
  // ****************************************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    #1 tp = task_pulse;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    // Let the write settle before any status port is looked at
    #1;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 got = rdata;
    chk(got, e);
  endtask

  task automatic tchk(input logic [11:0] e);
    chk({20'h0, tp}, {20'h0, e});
  endtask

  task automatic ev(input int i);
    @(posedge clk);
    hw_event <= 24'h1 << i;
    #1 tp = task_pulse;
    @(posedge clk);
    hw_event <= '0;
  endtask

  task automatic tick();
    @(posedge clk);
    bit_tick <= 1'b1;
    @(posedge clk);
    bit_tick <= 1'b0;
  endtask

  task automatic finish_test();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("Error at %0t: run did not end", $time);
    finish_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    bus_req = '0;
    hw_event = '0;
    bit_tick = 1'b0;
    strength_sample = 7'h5A;
    energy_sample = 8'hC3;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < NUM_HW_EVT; i++) rchk(EVT_OFS[i], 32'h0);
    rchk(OFS_EVENT_TASK_LINKS, RST_EVENT_TASK_LINKS);
    for (int i = 0; i < NUM_HW_EVT; i++) begin
      if (i == EV_BITCOUNT || i == EV_STRENGTH) continue;
      ev(i);
      tchk(12'h000);
      rchk(EVT_OFS[i], 32'h1);
      rchk(EVT_OFS[i], 32'h1);
      wr(EVT_OFS[i], 32'h0);
      rchk(EVT_OFS[i], 32'h0);
    end
    chk({24'h0, energy_sample_value}, 32'hC3);
    rchk(12'h668, 32'hC3);
    for (int k = 0; k < 8; k++) begin
      wr(OFS_TASK_STRENGTH_BEGIN + 12'(4 * k), 32'h1);
      tchk(12'h800 >> k);
      wr(OFS_TASK_STRENGTH_BEGIN + 12'(4 * k), 32'hFFFF_FFFE);
      tchk(12'h000);
      rchk(OFS_TASK_STRENGTH_BEGIN + 12'(4 * k), 32'h0);
    end
    rchk(12'h11C, 32'h1);
    rchk(12'h548, 32'h5A);
    chk({25'h0, strength_value}, 32'h5A);
    // Counter hits on the third counted bit, not before
    wr(12'h560, 32'd3);
    wr(OFS_TASK_BITCOUNT_BEGIN, 32'h1);
    chk({31'h0, bitcount_running}, 32'h1);
    tick();
    tick();
    rchk(12'h128, 32'h0);
    tick();
    rchk(12'h128, 32'h1);
    wr(OFS_TASK_BITCOUNT_HALT, 32'h1);
    chk({31'h0, bitcount_running}, 32'h0);
    wr(OFS_EVENT_TASK_LINKS, 32'hFFFF_FFFF);
    rchk(OFS_EVENT_TASK_LINKS, 32'h3F);
    for (int j = 0; j < 4; j++) begin
      ev(lev[j]);
      tchk(lexp[j]);
    end
    wr(12'h7F0, 32'hFFFF_FFFF);
    rchk(12'h7F0, 32'h0);
    finish_test();
  end
endmodule

`default_nettype wire
